// File: sse_pkg.sv
// Package: constants, types and helpers of the subtract/swap/xor/sleep executor
package sse_pkg;

  // ************************************************************
  // Register offsets (byte addresses on APB)
  // ************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000; // Command: op, operand, destination
  localparam logic [11:0] OFS_ACC = 12'h004; // Accumulator
  localparam logic [11:0] OFS_STATUS = 12'h008; // Flags and sleep control
  localparam logic [11:0] OFS_DIR_A = 12'h00C; // Port A direction, read only
  localparam logic [11:0] OFS_DIR_B = 12'h010; // Port B direction, read only
  localparam logic [11:0] OFS_DIR_C = 12'h014; // Port C direction, read only
  localparam logic [11:0] OFS_WDT = 12'h018; // Watchdog counter and prescaler, read only
  localparam logic [11:0] OFS_FILE_BASE = 12'h200; // First file register word
  localparam logic [11:0] OFS_FILE_LAST = 12'h3FC; // Last file register word

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_OP_LSB = 0; // Opcode, 4 bits
  localparam int CTRL_OPND_LSB = 4; // Literal or file address, 8 bits
  localparam int CTRL_DEST_BIT = 12; // Destination select
  localparam int CTRL_BUSY_BIT = 31; // Execution in progress
  localparam int ST_C_BIT = 0; // Carry
  localparam int ST_DC_BIT = 1; // Nibble borrow
  localparam int ST_Z_BIT = 2; // Zero
  localparam int ST_PD_BIT = 3; // Sleep entered, active low
  localparam int ST_TO_BIT = 4; // Watchdog expiry, active low
  localparam int ST_SLEEP_BIT = 5; // Sleep mode, read only
  localparam int ST_WAKE_BIT = 7; // Write one to leave sleep
  localparam int WDT_PRESC_LSB = 16; // Prescaler field in watchdog read

  // ************************************************************
  // Opcodes and operands
  // ************************************************************
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_LIT_SUB = 4'h1; // literal_minus_acc_op
  localparam logic [3:0] OP_FILE_SUB = 4'h2; // file_minus_acc_op
  localparam logic [3:0] OP_FILE_SUB_B = 4'h3; // file_minus_acc_borrow_op
  localparam logic [3:0] OP_SWAP = 4'h4; // nibble_exchange_op
  localparam logic [3:0] OP_LIT_XOR = 4'h5; // literal_xor_op
  localparam logic [3:0] OP_FILE_XOR = 4'h6; // file_xor_op
  localparam logic [3:0] OP_DIR = 4'h7; // direction_load_op
  localparam logic [3:0] OP_SLEEP = 4'h8; // Enter sleep
  localparam logic [7:0] DIR_A_SEL = 8'h05; // Operand for port A direction
  localparam logic [7:0] DIR_B_SEL = 8'h06; // Operand for port B direction
  localparam logic [7:0] DIR_C_SEL = 8'h07; // Operand for port C direction

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF; // All pins input
  localparam logic RST_FLAG = 1'b0; // C, DC, Z
  localparam logic RST_PD_N = 1'b1;
  localparam logic RST_TO_N = 1'b1;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8; // 125 MHz core clock
  localparam int WDT_TICK_NS = 1000; // Watchdog prescaler period
  localparam int WDT_TICK_CYCLES = WDT_TICK_NS / CLK_PERIOD_NS;

  // Execution sequence
  typedef enum logic [1:0] {EX_IDLE, EX_READ, EX_EXEC} sse_state_e;

  // Zero test of an 8-bit result
  function automatic logic sse_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

endpackage

// File: sse_file_mem.sv
// File register memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module sse_file_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  // Depth must fit the address
  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_chk
    $error("sse_file_mem: DEPTH does not fit AW");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage array

  // Write port and registered read of the same address
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// File: sse_alu.sv
// Combinational subtract, swap and xor unit
`timescale 1ns/1ns
`default_nettype none
module sse_alu
  import sse_pkg::*;
(
  input wire logic [3:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic [7:0] lit,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic nibble_borrow_out
);

  logic [7:0] minuend; // Literal or file value
  logic cin; // One, or carry as inverted borrow
  logic [8:0] diff; // Full difference with carry out
  logic [4:0] low; // Low nibble difference with carry out

  // Operand selection
  assign minuend = (op == OP_LIT_SUB) ? lit : fval;
  assign cin = (op == OP_FILE_SUB_B) ? carry_in : 1'b1; // RULE_04
  // Two's complement subtract: a + ~acc + cin
  assign diff = {1'b0, minuend} + {1'b0, ~acc} + {8'h00, cin}; // RULE_01
  assign low = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
  // Carry set when acc plus inverted carry in not above operand
  assign carry_out = diff[8]; // RULE_02
  assign nibble_borrow_out = low[4]; // RULE_02

  // Result selection
  always_comb
  begin
    case (op)
      OP_LIT_SUB, OP_FILE_SUB, OP_FILE_SUB_B: result = diff[7:0]; // RULE_03
      OP_SWAP: result = {fval[3:0], fval[7:4]}; // RULE_09
      OP_LIT_XOR: result = acc ^ lit; // RULE_10
      OP_FILE_XOR: result = acc ^ fval; // RULE_11
      default: result = acc;
    endcase
  end

endmodule
`default_nettype wire

// File: sse_exec.sv
// Executor for subtract, nibble swap, xor, direction load and sleep
// Function
// RULE_01 - Literal minus accumulator into accumulator
// RULE_02 - Subtracts set carry, nibble borrow, zero
// RULE_03 - File minus accumulator to chosen destination
// RULE_04 - Borrow form also subtracts inverted carry
// RULE_05 - Destination bit: 0 accumulator, 1 file
// RULE_06 - Sleep clears watchdog counter and prescaler
// RULE_07 - Sleep clears sleep bit, sets expiry bit
// RULE_08 - Sleep stops all further execution
// RULE_09 - Swap exchanges nibbles, flags untouched
// RULE_10 - Literal xor into accumulator, zero only
// RULE_11 - File xor to destination, zero only
// RULE_12 - Direction load copies accumulator, no flags
// RULE_13 - Zero flag set when result is zero
`timescale 1ns/1ns
`default_nettype none
module sse_exec #(
  parameter int WDT_TICK = sse_pkg::WDT_TICK_CYCLES,
  parameter int WDT_W = 8,
  parameter int FILE_DEPTH = 128
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic sleep_mode
);
  import sse_pkg::*;

  localparam int PW = (WDT_TICK > 1) ? $clog2(WDT_TICK) : 1; // Prescaler width

  // Parameter checks
  if (WDT_TICK < 2 || WDT_W < 1 || WDT_W > 16 || FILE_DEPTH != 128) begin : g_chk
    $error("sse_exec: unsupported parameter value");
  end

  // ************************************************************
  // State
  // ************************************************************
  sse_state_e state_r, state_nxt; // Execution sequence
  logic [3:0] op_r; // Latched opcode
  logic [7:0] opnd_r; // Latched literal or address
  logic dest_r; // Latched destination select
  logic [7:0] acc_r, acc_nxt; // Accumulator
  logic carry_r, carry_nxt; // Carry flag
  logic nibble_borrow_bit_r, nibble_borrow_bit_nxt; // Digit carry
  logic zero_r, zero_nxt; // Zero flag
  logic sleep_entered_bit_n_r; // Low once sleep was entered
  logic watchdog_expiry_bit_n_r; // High from reset and sleep; no time-out drives it low
  logic sleep_r; // Oscillator stopped
  logic [7:0] dir_a_r, dir_b_r, dir_c_r; // Port directions
  logic [WDT_W-1:0] watchdog_counter_r; // Watchdog count
  logic [PW-1:0] presc_r; // Watchdog prescaler
  logic pready_r, pslverr_r, frd_wait_r; // APB answer state
  logic [31:0] prdata_r; // APB read data

  // ************************************************************
  // APB decode
  // ************************************************************
  wire is_ctrl = (paddr == OFS_CTRL);
  wire is_acc = (paddr == OFS_ACC);
  wire is_status = (paddr == OFS_STATUS);
  wire is_dir_a = (paddr == OFS_DIR_A);
  wire is_dir_b = (paddr == OFS_DIR_B);
  wire is_dir_c = (paddr == OFS_DIR_C);
  wire is_wdt = (paddr == OFS_WDT);
  wire is_file = (paddr >= OFS_FILE_BASE) && (paddr <= OFS_FILE_LAST) && (paddr[1:0] == 2'b00);
  wire mapped = is_ctrl | is_acc | is_status | is_dir_a | is_dir_b | is_dir_c | is_wdt | is_file;
  wire busy = (state_r != EX_IDLE);
  wire acc_ph = psel & penable & ~pready_r; // Access phase not yet answered
  wire apb_done = psel & penable & pready_r; // Transfer completes this edge
  wire wr_done = apb_done & pwrite; // Writes take effect here only
  wire blocked = busy & (pwrite | is_file); // Wait for the executor to finish
  wire file_rd = is_file & ~pwrite;
  wire answer_now = acc_ph & ~blocked & (~file_rd | frd_wait_r);
  wire frd_start = acc_ph & ~blocked & file_rd & ~frd_wait_r;
  wire st_wr = wr_done & is_status;
  wire [3:0] wr_op = pwdata[CTRL_OP_LSB +: 4];
  wire launch = wr_done & is_ctrl & ~sleep_r & (wr_op != OP_NONE); // RULE_08

  // ************************************************************
  // Read data selection
  // ************************************************************
  wire [31:0] ctrl_rd = {busy, 18'h0_0000, dest_r, opnd_r, op_r};
  wire [31:0] status_rd = {24'h00_0000, 2'b00, sleep_r, watchdog_expiry_bit_n_r,
                           sleep_entered_bit_n_r, zero_r, nibble_borrow_bit_r, carry_r};
  wire [31:0] wdt_rd = {{(16 - PW){1'b0}}, presc_r, {(16 - WDT_W){1'b0}}, watchdog_counter_r};
  wire [31:0] reg_rdata = is_ctrl ? ctrl_rd :
                          is_acc ? {24'h00_0000, acc_r} :
                          is_status ? status_rd :
                          is_dir_a ? {24'h00_0000, dir_a_r} :
                          is_dir_b ? {24'h00_0000, dir_b_r} :
                          is_dir_c ? {24'h00_0000, dir_c_r} :
                          is_wdt ? wdt_rd : 32'h0000_0000;

  // ************************************************************
  // Datapath and routing
  // ************************************************************
  logic [7:0] mem_rdata; // File value, one cycle after address
  logic [7:0] alu_res; // Unit result
  logic alu_c, alu_dc; // Unit carries
  wire exec_fire = (state_r == EX_EXEC); // Result cycle
  wire is_sub = (op_r == OP_LIT_SUB) | (op_r == OP_FILE_SUB) | (op_r == OP_FILE_SUB_B);
  wire is_xor = (op_r == OP_LIT_XOR) | (op_r == OP_FILE_XOR);
  wire file_op = (op_r == OP_FILE_SUB) | (op_r == OP_FILE_SUB_B) | (op_r == OP_SWAP) |
                 (op_r == OP_FILE_XOR);
  wire to_file = exec_fire & file_op & dest_r; // RULE_05
  wire to_acc = exec_fire & ((file_op & ~dest_r) | (op_r == OP_LIT_SUB) | (op_r == OP_LIT_XOR));
  wire upd_cdc = exec_fire & is_sub; // RULE_02
  wire upd_z = exec_fire & (is_sub | is_xor); // RULE_10 RULE_11
  wire do_sleep = exec_fire & (op_r == OP_SLEEP);
  wire do_dir = exec_fire & (op_r == OP_DIR);
  wire tick = (presc_r == PW'(WDT_TICK - 1));
  wire mem_we = to_file | (wr_done & is_file);
  wire [6:0] mem_addr = busy ? opnd_r[6:0] : paddr[8:2];
  wire [7:0] mem_wdata = busy ? alu_res : pwdata[7:0];

  // Subtract, swap and xor unit
  sse_alu u_alu (
    .op(op_r),
    .acc(acc_r),
    .fval(mem_rdata),
    .lit(opnd_r),
    .carry_in(carry_r),
    .result(alu_res),
    .carry_out(alu_c),
    .nibble_borrow_out(alu_dc)
  );

  // File registers
  sse_file_mem #(.DEPTH(FILE_DEPTH), .AW(7), .WIDTH(8)) u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Next values: hardware results win over software writes
  always_comb
  begin
    acc_nxt = to_acc ? alu_res : ((wr_done & is_acc) ? pwdata[7:0] : acc_r); // RULE_05
    carry_nxt = upd_cdc ? alu_c : (st_wr ? pwdata[ST_C_BIT] : carry_r); // RULE_02
    nibble_borrow_bit_nxt = upd_cdc ? alu_dc : (st_wr ? pwdata[ST_DC_BIT] : nibble_borrow_bit_r);
    zero_nxt = upd_z ? sse_is_zero(alu_res) : (st_wr ? pwdata[ST_Z_BIT] : zero_r); // RULE_13
  end

  // Sequence: latch, read file, execute
  always_comb
  begin
    case (state_r)
      EX_IDLE: state_nxt = launch ? EX_READ : EX_IDLE; // RULE_08
      EX_READ: state_nxt = EX_EXEC;
      EX_EXEC: state_nxt = EX_IDLE;
      default: state_nxt = EX_IDLE;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Sequencer and command latch
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= EX_IDLE;
      op_r <= OP_NONE;
      opnd_r <= 8'h00;
      dest_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (wr_done & is_ctrl)
      begin
        op_r <= wr_op;
        opnd_r <= pwdata[CTRL_OPND_LSB +: 8];
        dest_r <= pwdata[CTRL_DEST_BIT];
      end
    end
  end

  // Accumulator and arithmetic flags
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r <= RST_ACC;
      carry_r <= RST_FLAG;
      nibble_borrow_bit_r <= RST_FLAG;
      zero_r <= RST_FLAG;
    end
    else
    begin
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      nibble_borrow_bit_r <= nibble_borrow_bit_nxt;
      zero_r <= zero_nxt;
    end
  end

  // Sleep entry, wake by software; entry wins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sleep_r <= 1'b0;
      sleep_entered_bit_n_r <= RST_PD_N;
      watchdog_expiry_bit_n_r <= RST_TO_N;
    end
    else if (do_sleep)
    begin
      sleep_r <= 1'b1; // RULE_08
      sleep_entered_bit_n_r <= 1'b0; // RULE_07
      watchdog_expiry_bit_n_r <= 1'b1; // RULE_07
    end
    else if (st_wr & pwdata[ST_WAKE_BIT])
    begin
      sleep_r <= 1'b0;
    end
  end

  // Watchdog prescaler and counter, cleared by sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      presc_r <= '0;
      watchdog_counter_r <= '0;
    end
    else if (do_sleep)
    begin
      presc_r <= '0; // RULE_06
      watchdog_counter_r <= '0; // RULE_06
    end
    else
    begin
      presc_r <= tick ? '0 : presc_r + PW'(1);
      watchdog_counter_r <= tick ? watchdog_counter_r + WDT_W'(1) : watchdog_counter_r;
    end
  end

  // Direction registers, no flag touched
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_a_r <= RST_DIR;
      dir_b_r <= RST_DIR;
      dir_c_r <= RST_DIR;
    end
    else if (do_dir)
    begin
      if (opnd_r == DIR_A_SEL) dir_a_r <= acc_r; // RULE_12
      if (opnd_r == DIR_B_SEL) dir_b_r <= acc_r; // RULE_12
      if (opnd_r == DIR_C_SEL) dir_c_r <= acc_r; // RULE_12
    end
  end

  // APB answer: ready one cycle, data and error with it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      frd_wait_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= answer_now;
      pslverr_r <= answer_now & ~mapped;
      frd_wait_r <= frd_start;
      if (answer_now)
      begin
        prdata_r <= frd_wait_r ? {24'h00_0000, mem_rdata} : reg_rdata;
      end
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign port_a_direction = dir_a_r;
  assign port_b_direction = dir_b_r;
  assign port_c_direction = dir_c_r;
  assign sleep_mode = sleep_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire [7:0] exp_lit_sub = opnd_r - acc_r; // Expected literal difference
  wire exp_c_lit = (acc_r <= opnd_r); // Expected carry
  wire exp_dc_lit = (acc_r[3:0] <= opnd_r[3:0]); // Expected nibble borrow
  wire [7:0] exp_borrow = mem_rdata - acc_r - {7'h00, ~carry_r}; // Borrow difference
  wire exp_xor_zero = ((acc_r ^ opnd_r) == 8'h00); // Literal xor zero
  wire [2:0] flags = {carry_r, nibble_borrow_bit_r, zero_r};

  a_lit_sub_value: assert property ((exec_fire && op_r == OP_LIT_SUB) |=>
    acc_r == $past(exp_lit_sub)) else $error("literal subtract result wrong"); // RULE_01
  a_sub_carry_flags: assert property ((exec_fire && op_r == OP_LIT_SUB) |=>
    carry_r == $past(exp_c_lit) && nibble_borrow_bit_r == $past(exp_dc_lit))
    else $error("subtract carry flags wrong"); // RULE_02
  a_borrow_to_acc: assert property ((exec_fire && op_r == OP_FILE_SUB_B && !dest_r) |=>
    acc_r == $past(exp_borrow)) else $error("borrow subtract wrong"); // RULE_04
  a_dest_file_keep: assert property ((exec_fire && file_op && dest_r) |-> mem_we ##1
    $stable(acc_r)) else $error("file destination disturbed acc"); // RULE_05
  a_sleep_clears_wdt: assert property (do_sleep |=> watchdog_counter_r == '0 &&
    presc_r == '0) else $error("sleep left watchdog running"); // RULE_06
  a_sleep_status_bits: assert property (do_sleep |=> !sleep_entered_bit_n_r &&
    watchdog_expiry_bit_n_r && sleep_r) else $error("sleep status bits wrong"); // RULE_07
  a_sleep_no_exec: assert property ((sleep_r && state_r == EX_IDLE) |=>
    state_r == EX_IDLE) else $error("executed while asleep"); // RULE_08
  a_swap_nibbles: assert property ((exec_fire && op_r == OP_SWAP && dest_r) |->
    mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]} ##1 $stable(flags))
    else $error("swap wrong or flags changed"); // RULE_09
  a_xor_zero_only: assert property ((exec_fire && op_r == OP_LIT_XOR) |=>
    zero_r == $past(exp_xor_zero) && $stable(carry_r) && $stable(nibble_borrow_bit_r))
    else $error("literal xor flags wrong"); // RULE_10
  a_dir_load_b: assert property ((do_dir && opnd_r == DIR_B_SEL) |=>
    dir_b_r == $past(acc_r) && $stable(flags)) else $error("direction load wrong"); // RULE_12
  a_launch_to_exec: assert property (launch |=> state_r == EX_READ ##1 state_r == EX_EXEC)
    else $error("execution sequence broken"); // RULE_03
  a_ready_pulse: assert property (pready_r |=> !pready_r) else $error("pready held");

  c_borrow_exec: cover property (exec_fire && op_r == OP_FILE_SUB_B);
  c_sleep_entry: cover property (do_sleep);
  c_file_write_back: cover property (to_file && op_r == OP_FILE_XOR);
  c_blocked_write: cover property (acc_ph && blocked);

endmodule
`default_nettype wire

// File: sse_tb.sv
// Self-checking testbench for the subtract, swap, xor, direction and sleep executor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sse_pkg::*;
  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sleep_mode, err;
  logic [7:0] dir_a, dir_b, dir_c;
  int failures = 0;
  int checked = 0;
  int seed = 32'ha881_07cc;
  int acc, c, dc, z, op, a, lit, d, f, r, x, ci, s0, flg;
  int dir [3] = '{255, 255, 255}; // Direction model, all inputs
  // ************************************************************
  // Clock and design
  // ************************************************************
  always #4 clk = ~clk;
  sse_exec #(.WDT_TICK(4)) uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .sleep_mode(sleep_mode));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Compare and count
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Sample pready at each rising edge; data and error taken at that same edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Launch a command and poll until the executor is idle
  task automatic exec(input int o, input int opnd, input int dst);
    int s;
    apb(1'b1, OFS_CTRL, 32'(o | (opnd << 4) | (dst << 12)));
    s = 0;
    do
    begin
      apb(1'b0, OFS_CTRL, 32'h0000_0000);
      s++;
    end
    while (rd[CTRL_BUSY_BIT] !== 1'b0 && s < 10);
    if (s >= 10) failures++;
  endtask
  // Print counts and verdict, then stop
  task automatic close_out();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ************************************************************
  // Watchdog against hangs
  // ************************************************************
  initial
  begin
    #(8 * 20000);
    failures++;
    close_out();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check("dir_a", dir_a, 8'hff);
    check("sleep", sleep_mode, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("status", rd[5:0], 6'h18);
    check("ok_err", err, 1'b0);
    // Random arithmetic; every fourth pass forces equal operands, zero result except for swap and for borrow with carry clear
    for (int i = 0; i < 80; i++)
    begin
      op = 1 + {$random(seed)} % 6;
      a = {$random(seed)} % 128;
      acc = {$random(seed)} % 256;
      f = (i % 4 == 0) ? acc : {$random(seed)} % 256;
      lit = (i % 4 == 0) ? acc : {$random(seed)} % 256;
      d = {$random(seed)} % 2;
      s0 = {$random(seed)} % 8;
      c = s0 & 1;
      dc = (s0 >> 1) & 1;
      z = (s0 >> 2) & 1;
      apb(1'b1, OFS_ACC, 32'(acc));
      apb(1'b1, 12'(OFS_FILE_BASE + 4 * a), 32'(f));
      apb(1'b1, OFS_STATUS, 32'(s0));
      // Literal forms always land in the accumulator
      if (op == 1 || op == 5)
        exec(op, lit, 0);
      else
        exec(op, a + 128 * ({$random(seed)} % 2), d);
      case (op)
        1, 2, 3:
        begin
          x = (op == 1) ? lit : f;
          ci = (op == 3) ? c : 1;
          r = x + (acc ^ 255) + ci;
          dc = ((x & 15) + ((acc ^ 255) & 15) + ci) >> 4;
          c = r >> 8;
          r = r & 255;
          z = (r == 0);
        end
        4: r = ((f << 4) | (f >> 4)) & 255;
        default:
        begin
          r = acc ^ ((op == 5) ? lit : f);
          z = (r == 0);
        end
      endcase
      if (op == 1 || op == 5 || d == 0)
        acc = r;
      else
        f = r;
      flg = 24 + z * 4 + dc * 2 + c;
      apb(1'b0, OFS_ACC, 32'h0000_0000);
      check("acc", rd, acc);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("flags", rd[5:0], flg);
      apb(1'b0, 12'(OFS_FILE_BASE + 4 * a), 32'h0000_0000);
      check("file", rd, f);
    end
    // Direction loads, then an operand outside 5 to 7
    for (int k = 0; k < 4; k++)
    begin
      acc = {$random(seed)} % 256;
      apb(1'b1, OFS_ACC, 32'(acc));
      exec(7, (k == 3) ? 4 : 5 + k, 0);
      if (k < 3) dir[k] = acc;
      check("dir_a", dir_a, dir[0]);
      check("dir_b", dir_b, dir[1]);
      check("dir_c", dir_c, dir[2]);
      apb(1'b0, 12'(OFS_DIR_A + 4 * (k % 3)), 32'h0000_0000);
      check("dir_reg", rd, dir[k % 3]);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("dir_flags", rd[5:0], flg);
    end
    // Sleep: watchdog read at once, then status bits
    apb(1'b1, OFS_CTRL, 32'(OP_SLEEP));
    apb(1'b0, OFS_WDT, 32'h0000_0000);
    check("wdt", rd[7:0], 8'h00);
    check("presc", rd[31:16], 16'h0000);
    check("sleep", sleep_mode, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("sl_status", rd[5:0], flg + 32 - 8);
    // A command while asleep must not run
    apb(1'b1, OFS_CTRL, 32'h0000_0ff0 | 32'(OP_LIT_XOR));
    repeat (6) @(posedge clk);
    apb(1'b0, OFS_ACC, 32'h0000_0000);
    check("asleep", rd, acc);
    apb(1'b1, OFS_STATUS, 32'(128 | (flg & 7)));
    // Wake lands at the completion edge; look one edge later
    @(posedge clk);
    check("woken", sleep_mode, 1'b0);
    exec(5, 15, 0);
    apb(1'b0, OFS_ACC, 32'h0000_0000);
    check("after", rd, acc ^ 15);
    // Unmapped and unaligned places
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check("unmapped_err", err, 1'b1);
    check("unmapped_rd", rd, 32'h0000_0000);
    apb(1'b1, 12'h006, 32'h0000_0055);
    check("unaligned", err, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
